// ==== src/pbr_defs.svh ====
// Offsets, field positions, reset values and masks of the port B routing registers
`ifndef PBR_DEFS_SVH
`define PBR_DEFS_SVH

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define PBR_OFF_STATUS 12'h0c8
`define PBR_OFF_ENABLES 12'h0cc
`define PBR_OFF_MASK 12'h0d0
`define PBR_OFF_ROUTE 12'h0d4
`define PBR_OFF_CTRL 12'h0e4
`define PBR_OFF_LOC_BASE 12'h100
`define PBR_LOC_SEL_HI 11
`define PBR_LOC_SEL_LO 5
`define PBR_LOC_IDX_HI 4
`define PBR_LOC_IDX_LO 2

//------------------------------------------------------------
// Field positions
//------------------------------------------------------------
`define PBR_BIT_INS 8
`define PBR_BIT_OVF 0
`define PBR_BIT_FILT_EN 0
`define PBR_BIT_INS_EN 1
`define PBR_ROUTE_STRIDE 4
`define PBR_NUM_LOC 8

//------------------------------------------------------------
// Writable masks and reset values
//------------------------------------------------------------
`define PBR_EVT_WMASK 32'h0000_0101
`define PBR_ROUTE_WMASK 32'h7777_7777
`define PBR_CTRL_WMASK 32'h0000_0003
`define PBR_RST_WORD 32'h0000_0000
`define PBR_ZERO_WORD 32'h0000_0000

`endif

// ==== src/pbr_pkg.sv ====
// Types shared by the port B routing register bank
package pbr_pkg;

    typedef logic [2:0] pbr_buf_t;
    typedef logic [2:0] pbr_loc_t;
    typedef logic [31:0] pbr_word_t;

endpackage : pbr_pkg

// ==== src/pbr_pid_match.sv ====
// Masked identifier compare against eight filter locations, lowest index wins
`timescale 1ns/1ps

module pbr_pid_match
(
    input wire pbr_pkg::pbr_word_t i_pid,
    input wire pbr_pkg::pbr_word_t i_mask,
    input wire logic [255:0] i_loc_pid,
    output logic o_any,
    output pbr_pkg::pbr_loc_t o_first
);
    import pbr_pkg::*;

    logic [7:0] hit;

    //------------------------------------------------------------
    // Per location compare
    //------------------------------------------------------------
    // Only bits with a one in the mask take part; an empty mask hits all
    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1)
        begin : g_loc
            assign hit[n] = (((i_pid ^ i_loc_pid[n*32 +: 32]) & i_mask) == 32'h0000_0000); // R4 R5
        end
    endgenerate

    //------------------------------------------------------------
    // Priority pick
    //------------------------------------------------------------
    // Scan downward so the lowest matching location is left standing
    always_comb
    begin
        o_first = 3'h0;
        for (int k = 7; k >= 0; k--)
        begin
            if (hit[k])
            begin
                o_first = pbr_loc_t'(k);
            end
        end
    end

    assign o_any = |hit;

endmodule : pbr_pid_match

// ==== src/pbr_regs_top.sv ====
// Port B interrupt enables, identifier mask and buffer routing behind an APB slave
`timescale 1ns/1ps
`include "pbr_defs.svh"

//------------------------------------------------------------
// Notes on behaviour
// R1 - Reserved bits of the enable and routing registers ignore writes and read as zero.
// R2 - Enable bit 8 lets a set insertion-done status bit drive the summary interrupt.
// R3 - Enable bit 0 lets a set transmit-overflow status bit drive the summary interrupt.
// R4 - Identifier compare looks only at bit positions where the mask holds a one.
// R5 - An all-zero mask compares nothing, so every packet passes the filter.
// R6 - A packet hitting location n goes to the buffer held in bits 4n+2 down to 4n.
// R7 - Insertion done sets its status bit and switches insertion off until re-enabled.
// R8 - An input buffer overflow on the port sets the transmit-overflow status bit.
// R9 - Summary is the OR of status AND enable per event; all fields reset to zero.
//------------------------------------------------------------

module pbr_regs_top
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire pbr_pkg::pbr_word_t i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic o_pslverr,
    output pbr_pkg::pbr_word_t o_prdata,
    input wire logic i_insert_done,
    input wire logic i_tx_overflow,
    input wire logic i_pid_valid,
    input wire pbr_pkg::pbr_word_t i_pid,
    output logic o_insert_enable,
    output logic o_filter_enable,
    output logic o_irq,
    output logic o_route_valid,
    output logic o_route_hit,
    output pbr_pkg::pbr_buf_t o_route_buf
);
    import pbr_pkg::*;

    //------------------------------------------------------------
    // Byte lane merge
    //------------------------------------------------------------
    function automatic pbr_word_t merge_lanes(input pbr_word_t old_v,
                                              input pbr_word_t new_v,
                                              input logic [3:0] strb);
        pbr_word_t r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_lanes

    //------------------------------------------------------------
    // Storage
    //------------------------------------------------------------
    pbr_word_t status_q;
    pbr_word_t status_d;
    pbr_word_t enables_q;
    pbr_word_t mask_q;
    pbr_word_t route_q;
    pbr_word_t ctrl_q;
    pbr_word_t ctrl_d;
    pbr_word_t loc_q [8];
    pbr_word_t prdata_q;
    logic route_valid_q;
    logic route_hit_q;
    pbr_buf_t route_buf_q;

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------
    logic setup_ph;
    logic wr_en;
    logic sel_status;
    logic sel_enables;
    logic sel_mask;
    logic sel_route;
    logic sel_ctrl;
    logic sel_loc;
    logic addr_hit;
    logic [2:0] loc_idx;
    logic [11:0] loc_base;
    pbr_word_t wr_word;
    pbr_word_t w1c_bits;
    pbr_word_t rd_fixed;
    pbr_word_t rd_mux;
    pbr_word_t evt_set;

    assign setup_ph = i_psel & ~i_penable;
    assign wr_en = i_psel & i_penable & i_pwrite & addr_hit;
    assign sel_status = (i_paddr == `PBR_OFF_STATUS);
    assign sel_enables = (i_paddr == `PBR_OFF_ENABLES);
    assign sel_mask = (i_paddr == `PBR_OFF_MASK);
    assign sel_route = (i_paddr == `PBR_OFF_ROUTE);
    assign sel_ctrl = (i_paddr == `PBR_OFF_CTRL);
    // Base held in a wire, since a literal cannot be part-selected
    assign loc_base = `PBR_OFF_LOC_BASE;
    // Filter locations sit eight words from the base; low two bits must be zero
    assign sel_loc = (i_paddr[`PBR_LOC_SEL_HI:`PBR_LOC_SEL_LO] ==
                      loc_base[`PBR_LOC_SEL_HI:`PBR_LOC_SEL_LO]) &&
                     (i_paddr[1:0] == 2'h0);
    assign loc_idx = i_paddr[`PBR_LOC_IDX_HI:`PBR_LOC_IDX_LO];
    assign addr_hit = sel_status | sel_enables | sel_mask | sel_route | sel_ctrl | sel_loc;

    // Zero wait states; the wait for read data is hidden in the setup phase
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_hit;

    //------------------------------------------------------------
    // Read select
    //------------------------------------------------------------
    // Stored values already hold zeros in reserved places, so no masking here
    assign rd_fixed = sel_status  ? status_q  :
                      sel_enables ? enables_q :
                      sel_mask    ? mask_q    :
                      sel_route   ? route_q   :
                      sel_ctrl    ? ctrl_q    : `PBR_ZERO_WORD; // R1
    assign rd_mux = sel_loc ? loc_q[loc_idx] : rd_fixed;

    // Read data is taken at the end of setup, so it comes from a flop
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            prdata_q <= `PBR_RST_WORD;
        else if (setup_ph && !i_pwrite)
            prdata_q <= rd_mux;
    end

    assign o_prdata = prdata_q;

    //------------------------------------------------------------
    // Write side helpers
    //------------------------------------------------------------
    assign wr_word = i_pwdata & {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                                 {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    assign w1c_bits = (wr_en && sel_status) ? (wr_word & `PBR_EVT_WMASK) : `PBR_ZERO_WORD;
    assign evt_set = {23'h00_0000, i_insert_done, 7'h00, i_tx_overflow}; // R7 R8

    //------------------------------------------------------------
    // Sticky status
    //------------------------------------------------------------
    // A new event in the same cycle as its clear still lands
    assign status_d = (status_q & ~w1c_bits) | evt_set; // R7 R8

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            status_q <= `PBR_RST_WORD;
        else
            status_q <= status_d;
    end

    //------------------------------------------------------------
    // Enables, mask and routing
    //------------------------------------------------------------
    // Write masks keep reserved bits at zero whatever software writes
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            enables_q <= `PBR_RST_WORD; // R9
            mask_q <= `PBR_RST_WORD; // R9
            route_q <= `PBR_RST_WORD; // R9
        end
        else if (wr_en)
        begin
            if (sel_enables)
                enables_q <= merge_lanes(enables_q, i_pwdata, i_pstrb) & `PBR_EVT_WMASK; // R1
            if (sel_mask)
                mask_q <= merge_lanes(mask_q, i_pwdata, i_pstrb);
            if (sel_route)
                route_q <= merge_lanes(route_q, i_pwdata, i_pstrb) & `PBR_ROUTE_WMASK; // R1
        end
    end

    //------------------------------------------------------------
    // Filter locations
    //------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PBR_NUM_LOC; g = g + 1)
        begin : g_loc
            always_ff @(posedge i_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    loc_q[g] <= `PBR_RST_WORD;
                else if (wr_en && sel_loc && (loc_idx == g))
                    loc_q[g] <= merge_lanes(loc_q[g], i_pwdata, i_pstrb);
            end
        end
    endgenerate

    //------------------------------------------------------------
    // Control: filter enable and insertion enable
    //------------------------------------------------------------
    // Insertion switches itself off when done; a software write that same
    // cycle wins, since it can only mean a deliberate re-arm
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (i_insert_done)
            ctrl_d[`PBR_BIT_INS_EN] = 1'b0; // R7
        if (wr_en && sel_ctrl)
            ctrl_d = merge_lanes(ctrl_q, i_pwdata, i_pstrb) & `PBR_CTRL_WMASK;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ctrl_q <= `PBR_RST_WORD;
        else
            ctrl_q <= ctrl_d;
    end

    assign o_insert_enable = ctrl_q[`PBR_BIT_INS_EN];
    assign o_filter_enable = ctrl_q[`PBR_BIT_FILT_EN];

    //------------------------------------------------------------
    // Summary interrupt
    //------------------------------------------------------------
    assign o_irq = (status_q[`PBR_BIT_INS] & enables_q[`PBR_BIT_INS]) | // R2 R9
                   (status_q[`PBR_BIT_OVF] & enables_q[`PBR_BIT_OVF]); // R3 R9

    //------------------------------------------------------------
    // Identifier match and buffer routing
    //------------------------------------------------------------
    logic [255:0] loc_flat;
    logic any_hit;
    pbr_loc_t first_loc;
    pbr_buf_t sel_buf;

    generate
        for (g = 0; g < `PBR_NUM_LOC; g = g + 1)
        begin : g_flat
            assign loc_flat[g*32 +: 32] = loc_q[g];
        end
    endgenerate

    pbr_pid_match u_match
    (
        .i_pid(i_pid),
        .i_mask(mask_q),
        .i_loc_pid(loc_flat),
        .o_any(any_hit),
        .o_first(first_loc)
    );

    // Field for location n starts at bit 4n
    assign sel_buf = route_q[first_loc * `PBR_ROUTE_STRIDE +: 3]; // R6

    // One cycle latency; a disabled filter passes all to buffer 0, unmatched
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            route_valid_q <= 1'b0;
            route_hit_q <= 1'b0;
            route_buf_q <= 3'h0;
        end
        else
        begin
            route_valid_q <= i_pid_valid & (~o_filter_enable | any_hit); // R5
            route_hit_q <= i_pid_valid & o_filter_enable & any_hit; // R4
            route_buf_q <= (o_filter_enable && any_hit) ? sel_buf : 3'h0; // R6
        end
    end

    assign o_route_valid = route_valid_q;
    assign o_route_hit = route_hit_q;
    assign o_route_buf = route_buf_q;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_ins_event;
        i_insert_done && enables_q[`PBR_BIT_INS] && !(wr_en && sel_enables);
    endsequence

    sequence s_ovf_event;
        i_tx_overflow && enables_q[`PBR_BIT_OVF] && !(wr_en && sel_enables);
    endsequence

    sequence s_enables_read;
        setup_ph && !i_pwrite && sel_enables ##1 i_penable;
    endsequence

    sequence s_filtered_pkt;
        i_pid_valid && o_filter_enable;
    endsequence

    chk_ins_irq_on: assert property (s_ins_event |=> o_irq) // R2
        else $error("insertion event with enable did not raise irq");

    chk_ovf_irq_on: assert property (s_ovf_event |=> o_irq) // R3
        else $error("overflow event with enable did not raise irq");

    chk_irq_gated_off: assert property ((enables_q[`PBR_BIT_INS] == 1'b0) &&
                                        (status_q[`PBR_BIT_OVF] == 1'b0) |-> !o_irq) // R2 R9
        else $error("irq high with insertion disabled and no overflow");

    chk_rsvd_read_zero: assert property (s_enables_read |-> ((o_prdata &
                                         ~`PBR_EVT_WMASK) == `PBR_ZERO_WORD)) // R1
        else $error("reserved enable bits read nonzero");

    chk_route_rsvd_zero: assert property ((route_q & ~`PBR_ROUTE_WMASK) == `PBR_ZERO_WORD) // R1
        else $error("reserved routing bits hold ones");

    chk_ins_self_off: assert property (i_insert_done && !(wr_en && sel_ctrl) |=>
                                       status_q[`PBR_BIT_INS] && !o_insert_enable) // R7
        else $error("insertion done did not set status and disable insertion");

    chk_ovf_sticky: assert property (i_tx_overflow ##1 !w1c_bits[`PBR_BIT_OVF] |=>
                                     status_q[`PBR_BIT_OVF]) // R8
        else $error("overflow status not held");

    chk_mask_zero_pass: assert property ((s_filtered_pkt and (mask_q == `PBR_ZERO_WORD)) |=>
                                         o_route_valid && o_route_hit) // R5
        else $error("empty mask dropped a packet");

    chk_mask_ignore: assert property ((s_filtered_pkt and
                                      (((i_pid ^ loc_q[0]) & mask_q) == `PBR_ZERO_WORD)) |=>
                                      o_route_hit && (o_route_buf == $past(route_q[2:0]))) // R4 R6
        else $error("masked match on location 0 not routed to its buffer");

    chk_unmatched_drop: assert property ((s_filtered_pkt and !any_hit) |=> !o_route_valid) // R4
        else $error("unmatched packet passed an enabled filter");

    chk_route_buf: assert property (o_route_hit |-> o_route_buf == $past(sel_buf)) // R6
        else $error("routed buffer differs from location field");

endmodule : pbr_regs_top

// ==== sim/pbr_far_end.sv ====
// Far-side model: insertion hardware, input buffer and packet source of port B
`timescale 1ns/1ps

module pbr_far_end
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_send,
    input wire pbr_pkg::pbr_word_t i_pid_in,
    input wire logic i_ovf,
    input wire logic i_ins,
    output logic o_pid_valid,
    output pbr_pkg::pbr_word_t o_pid,
    output logic o_tx_overflow,
    output logic o_insert_done
);
    import pbr_pkg::*;

    //------------------------------------------------------------
    // Event and packet pulses
    //------------------------------------------------------------
    // Identifier flips when idle so a stale value never looks valid
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_pid_valid <= 1'b0;
            o_pid <= 32'h0000_0000;
            o_tx_overflow <= 1'b0;
            o_insert_done <= 1'b0;
        end
        else
        begin
            o_pid_valid <= i_send;
            o_pid <= i_send ? i_pid_in : ~o_pid;
            o_tx_overflow <= i_ovf;
            o_insert_done <= i_ins;
        end
    end
endmodule : pbr_far_end

// ==== sim/test_port_b_irq_enable_and_pid_route.sv ====
// Self-checking bench for the port B enables, identifier mask and routing
`timescale 1ns/1ps
`include "pbr_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got %h expected %h", $time, got, exp); end end

module test_port_b_irq_enable_and_pid_route;
    import pbr_pkg::*;

    //------------------------------------------------------------
    // Stimulus, outputs and scoreboard
    //------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    pbr_word_t pwdata = 32'h0000_0000;
    logic send = 1'b0;
    logic ovf = 1'b0;
    logic ins = 1'b0;
    pbr_word_t pid_in = 32'h0000_0000;
    logic pready, pslverr, irq, ins_en, filt_en, rvalid, rhit;
    logic pid_valid, tx_ovf, ins_done;
    pbr_word_t prdata, pid, base, route;
    pbr_buf_t rbuf;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 25894;
    logic [32:0] rd_q[$];
    logic [3:0] rt_q[$];
    logic [32:0] exp_rd;
    logic [3:0] exp_rt;
    logic [11:0] offs[5] = '{`PBR_OFF_STATUS, `PBR_OFF_ENABLES, `PBR_OFF_MASK,
        `PBR_OFF_ROUTE, `PBR_OFF_CTRL};

    always #12.5 clk = ~clk;

    pbr_regs_top i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
        .i_insert_done(ins_done), .i_tx_overflow(tx_ovf), .i_pid_valid(pid_valid),
        .i_pid(pid), .o_insert_enable(ins_en), .o_filter_enable(filt_en), .o_irq(irq),
        .o_route_valid(rvalid), .o_route_hit(rhit), .o_route_buf(rbuf));

    pbr_far_end i_far (.i_clk(clk), .i_rst_b(rst_b), .i_send(send), .i_pid_in(pid_in),
        .i_ovf(ovf), .i_ins(ins), .o_pid_valid(pid_valid), .o_pid(pid),
        .o_tx_overflow(tx_ovf), .o_insert_done(ins_done));

    // Results are taken at the rising edge that ends the access, as a bus master would
    always @(posedge clk)
    begin
        if (psel && penable && !pwrite && pready)
        begin
            exp_rd = rd_q.size() ? rd_q.pop_front() : 'x;
            `CHK({pslverr, prdata}, exp_rd)
        end
        if (rvalid)
        begin
            exp_rt = rt_q.size() ? rt_q.pop_front() : 'x;
            `CHK({rhit, rbuf}, exp_rt)
        end
    end

    // Hang guard, far above the roughly 150 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    //------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input pbr_word_t d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input pbr_word_t exp, input logic err);
        rd_q.push_back({err, exp});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Event pulse; status and interrupt settle one edge after the far side fires
    task automatic evt(input logic o, input logic i);
        @(posedge clk);
        ovf <= o;
        ins <= i;
        @(posedge clk);
        ovf <= 1'b0;
        ins <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : evt

    task automatic pkt(input pbr_word_t p, input logic hit, input pbr_buf_t b, input logic pass);
        if (pass)
            rt_q.push_back({hit, b});
        @(posedge clk);
        send <= 1'b1;
        pid_in <= p;
        @(posedge clk);
        send <= 1'b0;
    endtask : pkt

    task automatic irq_is(input logic v);
        @(negedge clk);
        `CHK(irq, v)
    endtask : irq_is

    task print_verdict;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        foreach (offs[k])
            rd(offs[k], 32'h0000_0000, 1'b0);
        $display("test reset_values done");
        apb(1'b1, `PBR_OFF_ENABLES, 32'hffff_ffff);
        rd(`PBR_OFF_ENABLES, 32'h0000_0101, 1'b0);
        apb(1'b1, `PBR_OFF_ROUTE, 32'hffff_ffff);
        rd(`PBR_OFF_ROUTE, 32'h7777_7777, 1'b0);
        base = $random(seed);
        apb(1'b1, `PBR_OFF_MASK, base);
        rd(`PBR_OFF_MASK, base, 1'b0);
        rd(12'h0f0, 32'h0000_0000, 1'b1);
        $display("test access_kinds done");
        apb(1'b1, `PBR_OFF_ENABLES, 32'h0000_0000);
        apb(1'b1, `PBR_OFF_CTRL, 32'h0000_0002);
        @(negedge clk);
        `CHK(ins_en, 1'b1)
        evt(1'b1, 1'b0);
        `CHK(irq, 1'b0)
        rd(`PBR_OFF_STATUS, 32'h0000_0001, 1'b0);
        apb(1'b1, `PBR_OFF_ENABLES, 32'h0000_0001);
        irq_is(1'b1);
        apb(1'b1, `PBR_OFF_STATUS, 32'h0000_0001);
        irq_is(1'b0);
        evt(1'b0, 1'b1);
        `CHK(irq, 1'b0)
        `CHK(ins_en, 1'b0)
        rd(`PBR_OFF_STATUS, 32'h0000_0100, 1'b0);
        apb(1'b1, `PBR_OFF_CTRL, 32'h0000_0002);
        @(negedge clk);
        `CHK(ins_en, 1'b1)
        apb(1'b1, `PBR_OFF_ENABLES, 32'h0000_0100);
        irq_is(1'b1);
        apb(1'b1, `PBR_OFF_STATUS, 32'hffff_ffff);
        irq_is(1'b0);
        $display("test interrupts done");
        route = $random(seed) & 32'h7777_7777;
        apb(1'b1, `PBR_OFF_ROUTE, route);
        for (int n = 0; n < 8; n++)
            apb(1'b1, `PBR_OFF_LOC_BASE + 12'(4 * n), base ^ n);
        apb(1'b1, `PBR_OFF_CTRL, 32'h0000_0001);
        @(negedge clk);
        `CHK(filt_en, 1'b1)
        apb(1'b1, `PBR_OFF_MASK, 32'hffff_ffff);
        for (int n = 0; n < 8; n++)
            pkt(base ^ n, 1'b1, route[4 * n +: 3], 1'b1);
        pkt(base ^ 32'h0000_0008, 1'b0, 3'h0, 1'b0);
        apb(1'b1, `PBR_OFF_MASK, 32'h0000_0003);
        pkt(base ^ 32'hffff_fff6, 1'b1, route[10:8], 1'b1);
        apb(1'b1, `PBR_OFF_MASK, 32'h0000_0000);
        pkt($random(seed), 1'b1, route[2:0], 1'b1);
        apb(1'b1, `PBR_OFF_CTRL, 32'h0000_0000);
        @(negedge clk);
        `CHK(filt_en, 1'b0)
        pkt($random(seed), 1'b0, 3'h0, 1'b1);
        repeat (4) @(posedge clk);
        `CHK(rt_q.size(), 0)
        $display("test routing done");
        print_verdict();
    end
endmodule : test_port_b_irq_enable_and_pid_route
